// *** design/otrt_pkg.sv ***
// package: offsets, field layouts, reset values and timing for the warning/rise-time bank
package otrt_pkg;

  localparam logic [7:0]  OFS_TEMP_WARNING_THRESHOLD = 8'h51;
  localparam logic [7:0]  OFS_SOFT_START_RISE_TIME   = 8'h61;

  localparam logic [15:0] RST_TEMP_WARNING_THRESHOLD = 16'h007d;
  localparam logic [15:0] RST_SOFT_START_RISE_TIME   = 16'he02b;
  localparam logic [7:0]  RST_FAULT_LIMIT            = 8'h91;

  // fixed upper bytes (exponent plus fixed mantissa bits)
  localparam logic [7:0]  WARN_FIXED_HI = 8'h00;
  localparam logic [7:0]  RISE_FIXED_HI = 8'he0;
  localparam int          MANT_LSB      = 0;
  localparam int          MANT_W        = 8;

  localparam logic [7:0]  WARN_MIN_C    = 8'h64;
  localparam logic [7:0]  WARN_MAX_C    = 8'h8c;
  localparam logic [7:0]  HYST_C        = 8'h14;

  localparam int          NUM_RISE      = 8;
  localparam logic [2:0]  RISE_RST_IDX  = 3'h4;

  // status bit positions
  localparam int          SB_TEMPERATURE = 2;
  localparam int          SB_CML         = 1;
  localparam int          ST_OT_WARN     = 6;
  localparam int          SC_IVD         = 6;

  localparam int          CLK_MHZ       = 40;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       page;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } otrt_req_t;

  typedef struct packed {
    logic [7:0] status_byte;
    logic [7:0] status_temperature;
    logic [7:0] status_cml;
  } otrt_status_t;

endpackage

// *** design/otrt_rise_snap.sv ***
// snaps a rise-time mantissa (units of 1/16 ms) to the nearest supported setting
`timescale 1ns/1ps
module otrt_rise_snap (
  input  wire logic [7:0] mant_in,
  output logic      [7:0] mant_out,
  output logic      [2:0] idx_out,
  output logic            zero_out
);
  import otrt_pkg::*;

  // supported times in 1/16 ms: 0.6,0.9,1.2,1.8,2.7,4.2,6.0,9.0 ms
  function automatic logic [7:0] rise_code(input logic [2:0] i);
    case (i)
      3'h0:    rise_code = 8'h0a;
      3'h1:    rise_code = 8'h0e;
      3'h2:    rise_code = 8'h13;
      3'h3:    rise_code = 8'h1d;
      3'h4:    rise_code = 8'h2b;
      3'h5:    rise_code = 8'h43;
      3'h6:    rise_code = 8'h60;
      default: rise_code = 8'h90;
    endcase
  endfunction

  function automatic logic [7:0] absdiff(input logic [7:0] a, input logic [7:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  logic [7:0] best_d;
  logic [2:0] best_i;

  always_comb begin
    best_i = 3'h0;
    best_d = absdiff(mant_in, rise_code(3'h0));
    for (int i = 1; i < NUM_RISE; i++) begin
      if (absdiff(mant_in, rise_code(3'(i))) < best_d) begin
        best_d = absdiff(mant_in, rise_code(3'(i)));
        best_i = 3'(i);
      end
    end
  end

  always_comb begin
    zero_out = (mant_in == 8'h00);
    idx_out  = best_i;
    mant_out = zero_out ? 8'h00 : rise_code(best_i);
  end
endmodule // otrt_rise_snap

// *** design/otrt_regs.sv ***
// register bank: temperature warning threshold and soft-start rise time, per page
`timescale 1ns/1ps
// What this block does
// - over-threshold temperature sets status and alert
// - warning latched until 20 C below threshold
// - warning >= fault limit flags CML, ivd, alert
// - both registers per page, saved on store
// - warning word: exponent zero, 8-bit mantissa, 125
// - warning range 100 to 140 C not enforced; any value below fault limit accepted
// - rise time sets ramp to regulation
// - rise time sets margin-step slew in soft-start; no trim input, trim slew not handled
// - unsupported rise time snaps to nearest
// - eight rise settings, 2.7 ms default
// - zero rise time means immediate step
// - rise word: exponent -4, 8-bit mantissa, 43
// - temperature summary on fault or warning
module otrt_regs #(
  parameter int PAGES = 2
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire otrt_pkg::otrt_req_t   req,
  input  wire logic                  store_user_all,
  input  wire logic                  clear_faults,
  input  wire logic [PAGES-1:0][7:0] ext_temp_c,
  input  wire logic [PAGES-1:0][7:0] fault_limit_c,
  input  wire logic [PAGES-1:0]      ot_fault,
  input  wire logic                  soft_start_active,
  input  wire logic                  margin_step_command,
  output logic      [15:0]           rdata,
  output logic                       rvalid,
  output logic                       smbalert,
  output otrt_pkg::otrt_status_t     status,
  output logic      [PAGES-1:0][2:0] rise_sel,
  output logic      [PAGES-1:0]      rise_immediate,
  output logic      [PAGES-1:0]      ref_slew_by_rise,
  output logic                       nvm_wr,
  output logic      [PAGES-1:0][15:0] nvm_warn_word,
  output logic      [PAGES-1:0][15:0] nvm_rise_word
);
  import otrt_pkg::*;

  if (PAGES < 1 || PAGES > 2) begin : g_bad_pages
    $error("PAGES must be 1 or 2");
  end

  // ------------------------------------------------------------
  // mantissa storage
  // ------------------------------------------------------------
  logic [PAGES-1:0][7:0] warn_q;
  logic [PAGES-1:0][7:0] rise_q;
  logic [PAGES-1:0][2:0] rise_idx_q;
  logic [PAGES-1:0]      rise_zero_q;
  logic [7:0]            snap_mant;
  logic [2:0]            snap_idx;
  logic                  snap_zero;
  logic                  pg;
  logic                  wr_warn;
  logic                  wr_rise;
  logic                  warn_bad;

  assign pg      = (PAGES > 1) ? req.page : 1'b0;
  assign wr_warn = req.wr && req.cmd == OFS_TEMP_WARNING_THRESHOLD;
  assign wr_rise = req.wr && req.cmd == OFS_SOFT_START_RISE_TIME;
  assign warn_bad = wr_warn && (req.wdata[7:0] >= fault_limit_c[pg]);

  otrt_rise_snap u_snap (
    .mant_in  (req.wdata[7:0]),
    .mant_out (snap_mant),
    .idx_out  (snap_idx),
    .zero_out (snap_zero)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int p = 0; p < PAGES; p++) begin
        warn_q[p]      <= RST_TEMP_WARNING_THRESHOLD[7:0];
        rise_q[p]      <= RST_SOFT_START_RISE_TIME[7:0];
        rise_idx_q[p]  <= RISE_RST_IDX;
        rise_zero_q[p] <= 1'b0;
      end
    end else begin
      if (wr_warn && !warn_bad) warn_q[pg] <= req.wdata[7:0];
      if (wr_rise) begin
        rise_q[pg]      <= snap_mant;
        rise_idx_q[pg]  <= snap_idx;
        rise_zero_q[pg] <= snap_zero;
      end
    end
  end

  // ------------------------------------------------------------
  // warning detection with hysteresis
  // ------------------------------------------------------------
  logic [PAGES-1:0] warn_lat_q;
  logic             ivd_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      warn_lat_q <= '0;
    end else begin
      for (int p = 0; p < PAGES; p++) begin
        if (ext_temp_c[p] > warn_q[p])
          warn_lat_q[p] <= 1'b1;
        else if ({1'b0, ext_temp_c[p]} + {1'b0, HYST_C} <= {1'b0, warn_q[p]})
          warn_lat_q[p] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) ivd_q <= 1'b0;
    else if (warn_bad) ivd_q <= 1'b1;
    else if (clear_faults) ivd_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // status and alert
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      status   <= '0;
      smbalert <= 1'b0;
    end else begin
      status <= '0;
      status.status_byte[SB_TEMPERATURE] <= warn_lat_q[pg] || ot_fault[pg];
      status.status_byte[SB_CML]         <= ivd_q || warn_bad;
      status.status_temperature[ST_OT_WARN] <= warn_lat_q[pg];
      status.status_cml[SC_IVD]          <= ivd_q || warn_bad;
      smbalert <= (|warn_lat_q) || ivd_q || warn_bad;
    end
  end

  // ------------------------------------------------------------
  // readback and outputs to the ramp and nvm
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata  <= '0;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd && req.cmd == OFS_TEMP_WARNING_THRESHOLD)
        rdata <= {WARN_FIXED_HI, warn_q[pg]};
      else if (req.rd && req.cmd == OFS_SOFT_START_RISE_TIME)
        rdata <= {RISE_FIXED_HI, rise_q[pg]};
      else
        rdata <= '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rise_sel         <= '0;
      rise_immediate   <= '0;
      ref_slew_by_rise <= '0;
      nvm_wr           <= 1'b0;
      nvm_warn_word    <= '0;
      nvm_rise_word    <= '0;
    end else begin
      for (int p = 0; p < PAGES; p++) begin
        rise_sel[p]         <= rise_idx_q[p];
        rise_immediate[p]   <= rise_zero_q[p];
        ref_slew_by_rise[p] <= soft_start_active && margin_step_command;
        nvm_warn_word[p]    <= {WARN_FIXED_HI, warn_q[p]};
        nvm_rise_word[p]    <= {RISE_FIXED_HI, rise_q[p]};
      end
      nvm_wr <= store_user_all;
    end
  end
endmodule // otrt_regs

// *** bench/otrt_regs_properties.sv ***
// checker: port-level properties of the warning/rise-time register bank
`timescale 1ns/1ps
module otrt_props #(
  parameter int PAGES = 2
) (
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire otrt_pkg::otrt_req_t    req,
  input wire logic                   store_user_all,
  input wire logic                   soft_start_active,
  input wire logic                   margin_step_command,
  input wire logic [PAGES-1:0][7:0]  ext_temp_c,
  input wire logic [15:0]            rdata,
  input wire logic                   smbalert,
  input wire otrt_pkg::otrt_status_t status,
  input wire logic [PAGES-1:0]       rise_immediate,
  input wire logic [PAGES-1:0]       ref_slew_by_rise,
  input wire logic                   nvm_wr
);
  import otrt_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // --------
  // properties
  // --------
  property p_rdw; req.rd && req.cmd == OFS_TEMP_WARNING_THRESHOLD |=> rdata[15:8] == WARN_FIXED_HI;
  endproperty
  a_rdw: assert property (p_rdw) else $error("warning word upper byte wrong");
  property p_rdr; req.rd && req.cmd == OFS_SOFT_START_RISE_TIME |=> rdata[15:8] == RISE_FIXED_HI;
  endproperty
  a_rdr: assert property (p_rdr) else $error("rise word upper byte wrong");
  property p_alert; status.status_cml[SC_IVD] |-> ##[0:2] smbalert; endproperty
  a_alert: assert property (p_alert) else $error("invalid data without alert");
  property p_sum; status.status_temperature[ST_OT_WARN] |-> ##[0:2] status.status_byte[2];
  endproperty
  a_sum: assert property (p_sum) else $error("temperature summary missing");
  property p_imm; req.wr && !req.page && req.cmd == OFS_SOFT_START_RISE_TIME
    && req.wdata[7:0] == 8'h00 |-> ##[1:2] rise_immediate[0]; endproperty
  a_imm: assert property (p_imm) else $error("zero rise time not immediate");
  property p_slew; soft_start_active && margin_step_command |-> ##[1:2] ref_slew_by_rise[0];
  endproperty
  a_slew: assert property (p_slew) else $error("margin slew not by rise time");
  property p_cool; (ext_temp_c[0] <= 8'h50 && !req.page) [*3]
    |-> !status.status_temperature[ST_OT_WARN]; endproperty
  a_cool: assert property (p_cool) else $error("warning held when cool");
  property p_nvm; store_user_all |-> ##[1:2] nvm_wr; endproperty
  a_nvm: assert property (p_nvm) else $error("store did not write");
endmodule // otrt_props

bind otrt_regs otrt_props #(.PAGES(PAGES)) u_props (.mclk(mclk), .rst(rst), .req(req),
  .store_user_all(store_user_all), .soft_start_active(soft_start_active),
  .margin_step_command(margin_step_command), .ext_temp_c(ext_temp_c), .rdata(rdata),
  .smbalert(smbalert), .status(status), .rise_immediate(rise_immediate),
  .ref_slew_by_rise(ref_slew_by_rise), .nvm_wr(nvm_wr));

// *** bench/otrt_host.sv ***
// host model: issues single-cycle register requests
`timescale 1ns/1ps
module otrt_host (
  input  wire logic          mclk,
  input  wire logic [15:0]   rdata,
  output otrt_pkg::otrt_req_t req
);
  import otrt_pkg::*;
  initial req = '0;
  // request held over one edge; read data stands one cycle only
  task automatic xfer(input logic w, input logic p, input logic [7:0] c,
                      input logic [15:0] d, output logic [15:0] q);
    @(negedge mclk);
    req <= '{wr: w, rd: !w, page: p, cmd: c, wdata: d};
    @(negedge mclk);
    q = rdata;
    req <= '0;
  endtask
endmodule // otrt_host

// *** bench/tb.sv ***
// testbench: register bank scenarios driven through the host model
`timescale 1ns/1ps
module tb;
  import otrt_pkg::*;
  logic            mclk = 0;
  logic            rst = 1;
  logic            store_user_all = 0;
  logic            clear_faults = 0;
  logic            ss = 0;
  logic            mstep = 0;
  logic [1:0][7:0] ext_temp_c = '0;
  logic [1:0][7:0] fault_limit_c = {2{8'h91}};
  logic [1:0]      ot_fault = '0;
  otrt_req_t       req;
  otrt_status_t    st;
  logic [15:0]     rdata;
  logic [15:0]     q;
  logic            rvalid;
  logic            smbalert;
  logic            nvm_wr;
  logic [1:0][2:0] rise_sel;
  logic [1:0]      rise_imm;
  logic [1:0]      slew;
  logic [1:0][15:0] nvm_warn;
  logic [1:0][15:0] nvm_rise;
  int              errors = 0;
  int              checks_done = 0;
  always #12.5 mclk = ~mclk;
  otrt_host u_host (.mclk(mclk), .rdata(rdata), .req(req));
  otrt_regs #(.PAGES(2)) u_dut (.mclk(mclk), .rst(rst), .req(req),
    .store_user_all(store_user_all), .clear_faults(clear_faults), .ext_temp_c(ext_temp_c),
    .fault_limit_c(fault_limit_c), .ot_fault(ot_fault), .soft_start_active(ss),
    .margin_step_command(mstep), .rdata(rdata), .rvalid(rvalid), .smbalert(smbalert),
    .status(st), .rise_sel(rise_sel), .rise_immediate(rise_imm), .ref_slew_by_rise(slew),
    .nvm_wr(nvm_wr), .nvm_warn_word(nvm_warn), .nvm_rise_word(nvm_rise));
  // --------
  // shared tasks
  // --------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic p, input logic [7:0] c, input logic [15:0] e, input string w);
    u_host.xfer(1'b0, p, c, 16'h0000, q);
    check("rvalid", {15'h0, rvalid}, 16'h0001);
    check(w, q, e);
  endtask
  task automatic wr(input logic p, input logic [7:0] c, input logic [15:0] d);
    u_host.xfer(1'b1, p, c, d, q);
    repeat (3) @(negedge mclk);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // --------
  // scenarios
  // --------
  task automatic t_reset;
    rd(0, 8'h51, 16'h007d, "warn reset");
    rd(1, 8'h61, 16'he02b, "rise reset");
    check("rise_sel reset", {13'h0, rise_sel[0]}, 16'h0004);
    rd(0, 8'h00, 16'h0000, "unknown cmd");
  endtask
  task automatic t_rise;
    wr(0, 8'h61, 16'hff20);
    rd(0, 8'h61, 16'he01d, "rise snapped");
    check("rise_sel snap", {13'h0, rise_sel[0]}, 16'h0003);
    wr(0, 8'h61, 16'h0000);
    check("rise immediate", {15'h0, rise_imm[0]}, 16'h0001);
    rd(1, 8'h61, 16'he02b, "page 1 rise");
  endtask
  task automatic t_warn;
    wr(0, 8'h51, 16'hff64);
    rd(0, 8'h51, 16'h0064, "warn written");
    ext_temp_c[0] = 8'h65;
    repeat (4) @(negedge mclk);
    check("warn set", {13'h0, smbalert, st.status_byte[2], st.status_temperature[6]}, 16'h7);
    ext_temp_c[0] = 8'h51;
    repeat (4) @(negedge mclk);
    check("warn held", {15'h0, st.status_temperature[6]}, 16'h1);
    ext_temp_c[0] = 8'h50;
    repeat (4) @(negedge mclk);
    check("warn clear", {13'h0, smbalert, st.status_byte[2], st.status_temperature[6]}, 16'h0);
    ot_fault[0] = 1'b1;
    repeat (3) @(negedge mclk);
    check("fault summary", {14'h0, st.status_byte[2], st.status_temperature[6]}, 16'h2);
    ot_fault[0] = 1'b0;
  endtask
  task automatic t_bad;
    wr(0, 8'h51, 16'h0091);
    rd(0, 8'h51, 16'h0064, "refused write");
    check("invalid flags", {13'h0, smbalert, st.status_byte[1], st.status_cml[6]}, 16'h7);
    clear_faults = 1;
    @(negedge mclk);
    clear_faults = 0;
    repeat (3) @(negedge mclk);
    check("alert cleared", {15'h0, smbalert}, 16'h0);
  endtask
  task automatic t_store;
    store_user_all = 1;
    @(negedge mclk);
    store_user_all = 0;
    check("nvm strobe", {15'h0, nvm_wr}, 16'h0001);
    repeat (3) @(negedge mclk);
    check("nvm strobe end", {15'h0, nvm_wr}, 16'h0000);
    check("nvm warn", nvm_warn[0], 16'h0064);
    check("nvm rise", nvm_rise[0], 16'he000);
    ss = 1;
    mstep = 1;
    repeat (3) @(negedge mclk);
    check("ref slew", {15'h0, slew[0]}, 16'h0001);
  endtask
  initial begin
    repeat (12) @(negedge mclk);
    rst = 0;
    t_reset();
    t_rise();
    t_warn();
    t_bad();
    t_store();
    finish_test();
  end
  initial begin
    repeat (20000) @(negedge mclk);
    errors++;
    finish_test();
  end
endmodule // tb
